// File: osr_host_model.sv
module osr_host_model (
    // Serial pins
    output logic sck,
    output logic csN,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Frame timing
    // Half period of the link clock; the bench may slow it down
    int halfNs = 24;

    // Mode 0: clock idles low between frames, select idles high
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end

    // ==========================================================
    // One bit: drive while low, sample on the rising edge
    task automatic bit_xfer(input logic d, output logic q);
        mosi = d;
        #(halfNs);
        sck = 1'b1;
        q = miso;
        #(halfNs);
        sck = 1'b0;
    endtask

    // Whole frame: tx bytes, then nRx filler bytes, then extra loose bits
    task automatic frame(input logic [7:0] tx[$], input int nRx, input int extra,
                         output logic [7:0] rx[$]);
        logic [7:0] b;
        logic [7:0] r;
        rx = {};
        csN = 1'b0;
        #(halfNs);
        for (int i = 0; i < tx.size() + nRx; i++) begin
            b = (i < tx.size()) ? tx[i] : 8'hFF;
            for (int j = 7; j >= 0; j--) begin
                bit_xfer(b[j], r[j]);
            end
            rx.push_back(r);
        end
        // Loose bits leave the select rise off a byte boundary
        for (int j = 0; j < extra; j++) begin
            bit_xfer(1'b0, r[0]);
        end
        #(halfNs);
        csN = 1'b1;
        // Released line must not keep showing the last bit
        mosi = ~mosi;
        #(4 * halfNs);
    endtask
endmodule

// File: osr_link_if.sv
interface osr_link_if;
    logic sckRise;
    logic sckFall;
    logic csActive;
    logic csRise;
    logic mosi;
    modport pins (output sckRise, output sckFall, output csActive, output csRise, output mosi);
    modport core (input sckRise, input sckFall, input csActive, input csRise, input mosi);
endinterface

// File: osr_otp_access.sv
module osr_otp_access #(
    parameter int PROG_CYCLES = osr_pkg::PROG_CYCLES,
    parameter logic [511:0] FACTORY_VALUE = {64{8'hA5}} // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial pins
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    // Status view
    output logic writeEnableLatch,
    output logic readyBusyFlag,
    output logic userLocked
);
    osr_link_if link ();
    logic progStart;
    logic progBusy;
    logic progDone;

    osr_pin_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .sck(sck),
        .csN(csN),
        .mosiPin(mosi),
        .link(link.pins)
    );

    osr_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(progStart),
        .busy(progBusy),
        .done(progDone)
    );

    // ==========================================================
    // Storage
    // Power-up values model nonvolatile cells, so reset leaves them alone
    logic [7:0] userMem_q [osr_pkg::USER_BYTES] = '{default: osr_pkg::ERASED};
    logic [7:0] buf_q [osr_pkg::BUF_BYTES];
    logic [osr_pkg::USER_BYTES-1:0] bufValid_q;
    logic [osr_pkg::USER_BYTES-1:0] commitMask_q;
    logic locked_q = 1'b0;
    logic wel_q;

    // ==========================================================
    // Command decoder
    osr_pkg::osr_phase_t phase_q;
    logic [7:0] opcode_q;
    logic [7:0] shiftIn_q;
    logic [2:0] bitCnt_q;
    logic [1:0] byteCnt_q;
    logic [23:0] addr_q;
    logic [5:0] wrPtr_q;
    logic gotData_q;
    logic [6:0] rdPtr_q;
    logic [7:0] shiftOut_q;
    logic outBits_q;
    logic [7:0] rxByte;
    logic byteDone;
    logic aligned;
    logic progOk;
    logic progAbort;
    logic [7:0] statusByte;

    assign rxByte = {shiftIn_q[6:0], link.mosi};
    assign byteDone = link.sckRise && (bitCnt_q == 3'h7);
    assign aligned = (bitCnt_q == 3'h0);
    assign progOk = (opcode_q == osr_pkg::OP_PROG) && (phase_q == osr_pkg::ST_DATA)
        && gotData_q && aligned && wel_q && !locked_q && !progBusy;
    assign progAbort = link.csRise && (opcode_q == osr_pkg::OP_PROG) && !progOk;
    assign progStart = link.csRise && progOk;

    // Status is rebuilt every cycle so each repeated byte shows fresh busy
    always_comb begin
        statusByte = 8'h00;
        statusByte[osr_pkg::SR_BUSY_BIT] = progBusy;
        statusByte[osr_pkg::SR_WEL_BIT] = wel_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt_q <= 3'h0;
            shiftIn_q <= 8'h00;
        end else if (!link.csActive) begin
            bitCnt_q <= 3'h0;
        end else if (link.sckRise) begin
            bitCnt_q <= bitCnt_q + 3'h1;
            shiftIn_q <= rxByte;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= osr_pkg::ST_OPCODE;
            opcode_q <= 8'h00;
            byteCnt_q <= 2'h0;
            addr_q <= 24'h000000;
            gotData_q <= 1'b0;
        end else if (!link.csActive) begin
            phase_q <= osr_pkg::ST_OPCODE;
            opcode_q <= 8'h00;
            byteCnt_q <= 2'h0;
            gotData_q <= 1'b0;
        end else if (byteDone) begin
            case (phase_q)
                osr_pkg::ST_OPCODE: begin
                    opcode_q <= rxByte;
                    byteCnt_q <= 2'h0;
                    if (rxByte == osr_pkg::OP_PROG || rxByte == osr_pkg::OP_READ) begin
                        phase_q <= osr_pkg::ST_ADDR;
                    end else begin
                        phase_q <= osr_pkg::ST_IGNORE;
                    end
                end
                osr_pkg::ST_ADDR: begin
                    addr_q <= {addr_q[15:0], rxByte};
                    byteCnt_q <= byteCnt_q + 2'h1;
                    if (byteCnt_q == 2'(osr_pkg::ADDR_BYTES - 1)) begin
                        byteCnt_q <= 2'h0;
                        phase_q <= (opcode_q == osr_pkg::OP_READ) ? osr_pkg::ST_DUMMY
                            : osr_pkg::ST_DATA;
                    end
                end
                osr_pkg::ST_DUMMY: begin
                    byteCnt_q <= byteCnt_q + 2'h1;
                    if (byteCnt_q == 2'(osr_pkg::DUMMY_BYTES - 1)) begin
                        phase_q <= osr_pkg::ST_DATA;
                    end
                end
                osr_pkg::ST_DATA: begin
                    gotData_q <= 1'b1;
                end
                osr_pkg::ST_IGNORE: begin
                    phase_q <= osr_pkg::ST_IGNORE;
                end
                default: begin
                    phase_q <= osr_pkg::ST_IGNORE;
                end
            endcase
        end
    end

    // ==========================================================
    // Program buffer
    // Whole 256-byte buffer cleared, only low 64 entries reach the array
    always_ff @(posedge clk) begin
        if (link.csActive && byteDone && phase_q == osr_pkg::ST_ADDR
                && byteCnt_q == 2'(osr_pkg::ADDR_BYTES - 1) && opcode_q == osr_pkg::OP_PROG) begin
            for (int i = 0; i < osr_pkg::BUF_BYTES; i++) begin
                buf_q[i] <= osr_pkg::ERASED;
            end
        end else if (link.csActive && byteDone && phase_q == osr_pkg::ST_DATA
                && opcode_q == osr_pkg::OP_PROG) begin
            buf_q[wrPtr_q] <= rxByte;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= 6'h00;
            bufValid_q <= '0;
        end else if (link.csActive && byteDone && opcode_q == osr_pkg::OP_PROG) begin
            if (phase_q == osr_pkg::ST_ADDR && byteCnt_q == 2'(osr_pkg::ADDR_BYTES - 1)) begin
                wrPtr_q <= rxByte[5:0];
                bufValid_q <= '0;
            end else if (phase_q == osr_pkg::ST_DATA) begin
                wrPtr_q <= wrPtr_q + 6'h01;
                bufValid_q[wrPtr_q] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Nonvolatile array and lock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            commitMask_q <= '0;
        end else if (progStart) begin
            commitMask_q <= bufValid_q;
        end
    end

    generate
        for (genvar g = 0; g < osr_pkg::USER_BYTES; g++) begin : gUser
            always_ff @(posedge clk) begin
                if (progDone && commitMask_q[g]) begin
                    userMem_q[g] <= buf_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (progStart) begin
            locked_q <= 1'b1;
        end
    end

    // ==========================================================
    // Write enable latch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wel_q <= 1'b0;
        end else if (progAbort) begin
            wel_q <= 1'b0;
        end else if (progStart) begin
            wel_q <= 1'b0;
        end else if (link.csRise && opcode_q == osr_pkg::OP_WREN && aligned
                && phase_q == osr_pkg::ST_IGNORE) begin
            wel_q <= 1'b1;
        end
    end

    // ==========================================================
    // Serial output
    function automatic logic [7:0] areaByte(input logic [6:0] a);
        areaByte = a[6] ? FACTORY_VALUE[8*a[5:0] +: 8] : userMem_q[a[5:0]];
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdPtr_q <= 7'h00;
            shiftOut_q <= 8'h00;
            outBits_q <= 1'b0;
        end else if (!link.csActive) begin
            outBits_q <= 1'b0;
        end else if (byteDone && phase_q == osr_pkg::ST_OPCODE && rxByte == osr_pkg::OP_RDSR) begin
            shiftOut_q <= statusByte;
            outBits_q <= 1'b1;
        end else if (byteDone && phase_q == osr_pkg::ST_DUMMY
                && byteCnt_q == 2'(osr_pkg::DUMMY_BYTES - 1)) begin
            shiftOut_q <= areaByte(addr_q[6:0]);
            rdPtr_q <= addr_q[6:0] + 7'h01;
            outBits_q <= 1'b1;
        end else if (byteDone && outBits_q) begin
            if (opcode_q == osr_pkg::OP_RDSR) begin
                shiftOut_q <= statusByte;
            end else begin
                shiftOut_q <= areaByte(rdPtr_q);
                rdPtr_q <= rdPtr_q + 7'h01;
            end
        end else if (link.sckRise && outBits_q) begin
            shiftOut_q <= {shiftOut_q[6:0], 1'b0};
        end
    end

    // Output updates on falling sck, first bit as soon as output turns on, so the host samples a settled bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            misoOut <= 1'b0;
            misoOe <= 1'b0;
        end else if (!link.csActive || !outBits_q) begin
            misoOe <= 1'b0;
        end else if (link.sckFall || !misoOe) begin
            misoOut <= shiftOut_q[7];
            misoOe <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            writeEnableLatch <= 1'b0;
            readyBusyFlag <= 1'b0;
            userLocked <= 1'b0;
        end else begin
            writeEnableLatch <= wel_q;
            readyBusyFlag <= progBusy;
            userLocked <= locked_q;
        end
    end

    // ==========================================================
    // Checks
    sequence sProgLaunch;
        progStart ##1 progBusy;
    endsequence

    a_prog_clears_wel: assert property (@(posedge clk) disable iff (!rst_b)
        sProgLaunch |-> !wel_q) else $error("latch still set after program start");
    a_abort_clears_wel: assert property (@(posedge clk) disable iff (!rst_b)
        progAbort |=> !wel_q) else $error("latch kept after abort");
    a_locked_refuse: assert property (@(posedge clk) disable iff (!rst_b)
        locked_q |-> !progStart) else $error("program started while locked");
    a_busy_status: assert property (@(posedge clk) disable iff (!rst_b)
        progStart |=> statusByte[osr_pkg::SR_BUSY_BIT]) else $error("busy not reported");
    a_lock_on_start: assert property (@(posedge clk) disable iff (!rst_b)
        progStart |=> locked_q) else $error("lock not set at start");
    a_read_hiz: assert property (@(posedge clk) disable iff (!rst_b)
        !link.csActive |=> !misoOe) else $error("output driven without select");
    a_start_aligned: assert property (@(posedge clk) disable iff (!rst_b)
        progStart |-> gotData_q && aligned) else $error("program started on bad frame");
    a_wren_sets: assert property (@(posedge clk) disable iff (!rst_b)
        link.csRise && opcode_q == osr_pkg::OP_WREN && aligned && !progAbort |=> wel_q)
        else $error("write enable not latched");

    // ==========================================================
    // Data path checks
    // Frame steps are named once so each property reads as its rule
    sequence sProgByte;
        link.csActive && byteDone && phase_q == osr_pkg::ST_DATA
            && opcode_q == osr_pkg::OP_PROG;
    endsequence

    sequence sProgLast;
        link.csActive && byteDone && phase_q == osr_pkg::ST_DATA
            && opcode_q == osr_pkg::OP_PROG && wrPtr_q == 6'h3F;
    endsequence

    sequence sReadLast;
        link.csActive && byteDone && outBits_q && phase_q == osr_pkg::ST_DATA
            && opcode_q == osr_pkg::OP_READ && rdPtr_q == 7'h7F;
    endsequence

    a_prog_advance: assert property (@(posedge clk) disable iff (!rst_b)
        sProgByte |=> wrPtr_q == $past(wrPtr_q) + 6'h01)
        else $error("program pointer did not advance");

    a_prog_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        sProgLast |=> wrPtr_q == 6'h00) else $error("program pointer did not wrap");

    a_read_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        sReadLast |=> rdPtr_q == 7'h00) else $error("read pointer did not wrap");

    a_select_ends: assert property (@(posedge clk) disable iff (!rst_b)
        !link.csActive |=> !outBits_q) else $error("output kept after select rise");

    // A refused frame must not burn the one-time region
    a_abort_no_lock: assert property (@(posedge clk) disable iff (!rst_b)
        progAbort && !locked_q |=> !locked_q) else $error("abort locked region");

    a_mem_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !progDone |=> userMem_q[0] == $past(userMem_q[0]))
        else $error("user byte changed outside program");
endmodule

// File: osr_pin_sync.sv
module osr_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Raw pins
    input wire logic sck,
    input wire logic csN,
    input wire logic mosiPin,
    // Conditioned link
    osr_link_if.pins link
);
    logic [1:0] sckS_q;
    logic [1:0] csS_q;
    logic [1:0] mosiS_q;
    logic sckOld_q;
    logic csOld_q;

    // Second stage drives the link outputs and also feeds the edge-detect registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sckS_q <= 2'h0;
            csS_q <= 2'h3;
            mosiS_q <= 2'h0;
            sckOld_q <= 1'b0;
            csOld_q <= 1'b1;
        end else begin
            sckS_q <= {sckS_q[0], sck};
            csS_q <= {csS_q[0], csN};
            mosiS_q <= {mosiS_q[0], mosiPin};
            sckOld_q <= sckS_q[1];
            csOld_q <= csS_q[1];
        end
    end

    assign link.sckRise = sckS_q[1] & ~sckOld_q & ~csS_q[1];
    assign link.sckFall = ~sckS_q[1] & sckOld_q & ~csS_q[1];
    assign link.csActive = ~csS_q[1];
    assign link.csRise = csS_q[1] & ~csOld_q;
    assign link.mosi = mosiS_q[1];
endmodule

// File: osr_pkg.sv
// Behaviour
// - A 128-byte security area; locations 0 to 63 are user one-time programmable.
// - Locations 64 to 127 hold a fixed factory value no command alters.
// - Program needs no erase and covers the whole 64-byte user region at once.
// - After any program of the user region, every later program is refused.
// - Program is opcode 9Bh followed by three address bytes.
// - Address bits 23 down to 6 are ignored by the program command.
// - Data bytes land in the buffer at positions following the start address.
// - Data past the end of the user region wraps back to location zero.
// - With more than 64 data bytes only the last 64 are kept.
// - Chip-select rise starts a self-timed write of the buffered bytes.
// - User locations that received no data stay at FFh.
// - Abort unless full address, one whole data byte and aligned select rise.
// - Any program abort clears the write enable latch.
// - Status reads report busy while the program operation runs.
// - Write enable latch clears before the program operation completes.
// - Program uses the shared 256-byte buffer, overwriting earlier contents.
// - Read is opcode 77h, three address bytes, two dummy bytes, then data.
// - Read past 7Fh wraps to 000000h with no delay.
// - Select rise ends a read at any bit; serial output goes high impedance.
// - Write enable is 06h; latch sets at a byte-aligned select rise.
// - Status read is 05h, repeats status bytes; bit 0 is busy.
package osr_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_PROG = 8'h9B;
    localparam logic [7:0] OP_READ = 8'h77;
    localparam int AREA_BYTES = 128;
    localparam int USER_BYTES = 64;
    localparam int BUF_BYTES = 256;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam int ADDR_BYTES = 3;
    localparam int DUMMY_BYTES = 2;
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WEL_BIT = 1;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OTP_PROGRAM_TIME_US = 500;
    localparam int PROG_CYCLES = (OTP_PROGRAM_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int WEL_CLEAR_CYCLE = 1;
    typedef enum {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} osr_phase_t;
endpackage

// File: osr_prog_timer.sv
module osr_prog_timer #(
    parameter int CYCLES = osr_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count_q;

    initial begin
        if (CYCLES < 2) $error("CYCLES must be at least 2");
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (start) begin
            count_q <= CW'(CYCLES);
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign busy = (count_q != '0);
    assign done = (count_q == CW'(1));
endmodule

// File: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Setup
    // Short program time keeps the run brief; busy polling still sees it
    localparam int PROG = 400;

    function automatic logic [511:0] fact_val();
        logic [511:0] f;
        for (int n = 0; n < 64; n++) f[8 * n +: 8] = 8'hC0 ^ 8'(n);
        return f;
    endfunction

    localparam logic [511:0] FACT = fact_val();

    logic clk;
    logic rst_b;
    wire sck;
    wire csN;
    wire mosi;
    wire miso;
    logic misoOut;
    logic misoOe;
    logic writeEnableLatch;
    logic readyBusyFlag;
    logic userLocked;
    int n_errors = 0;
    int n_checks = 0;
    int busyCnt = 0;
    logic [7:0] rx[$];
    logic [7:0] img[128];

    assign miso = misoOe ? misoOut : 1'bz;

    osr_otp_access #(.PROG_CYCLES(PROG), .FACTORY_VALUE(FACT)) i_osr_otp_access (
        .clk(clk), .rst_b(rst_b), .sck(sck), .csN(csN), .mosi(mosi),
        .misoOut(misoOut), .misoOe(misoOe), .writeEnableLatch(writeEnableLatch),
        .readyBusyFlag(readyBusyFlag), .userLocked(userLocked));

    osr_host_model i_osr_host_model (.sck(sck), .csN(csN), .mosi(mosi), .miso(miso));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (readyBusyFlag === 1'b1) busyCnt++;
    end

    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wren(input int extra);
        logic [7:0] q[$];
        q = {osr_pkg::OP_WREN};
        i_osr_host_model.frame(q, 0, extra, rx);
    endtask

    task automatic status(output logic [7:0] s);
        logic [7:0] q[$];
        q = {osr_pkg::OP_RDSR};
        i_osr_host_model.frame(q, 2, 0, rx);
        s = rx[1];
    endtask

    task automatic read_check(input logic [7:0] start, input int count, input int extra);
        logic [7:0] q[$];
        q = {osr_pkg::OP_READ, 8'h00, 8'h00, start, 8'h00, 8'h00};
        i_osr_host_model.frame(q, count, extra, rx);
        for (int k = 0; k < count; k++) begin
            check(rx[6 + k], img[(int'(start) + k) % 128]);
        end
        check({7'h00, misoOe}, 8'h00);
    endtask

    task automatic flags(input logic [7:0] exp);
        repeat (10) @(posedge clk);
        check({5'h00, userLocked, writeEnableLatch, readyBusyFlag}, exp);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_erased();
        read_check(8'h7E, 130, 0);
        read_check(8'h41, 1, 5);
    endtask

    task automatic t_wren();
        logic [7:0] s;
        wren(3);
        flags(8'h00);
        wren(0);
        flags(8'h02);
        status(s);
        check(s, 8'h02);
        check(rx[2], 8'h02);
    endtask

    task automatic t_aborts();
        int nA[5] = '{2, 3, 3, 3, 3};
        int nD[5] = '{0, 0, 0, 1, 1};
        int nX[5] = '{0, 0, 5, 3, 0};
        logic [7:0] q[$];
        for (int i = 0; i < 5; i++) begin
            // Last case is a full command sent without write enable
            if (i < 4) wren(0);
            q = {osr_pkg::OP_PROG};
            for (int a = 0; a < nA[i]; a++) q.push_back(8'h00);
            for (int d = 0; d < nD[i]; d++) q.push_back(8'h33);
            i_osr_host_model.frame(q, 0, nX[i], rx);
            flags(8'h00);
        end
        read_check(8'h00, 2, 0);
    endtask

    task automatic t_program();
        logic [7:0] q[$];
        logic [7:0] s;
        int polls;
        wren(0);
        q = {osr_pkg::OP_PROG, 8'hFF, 8'hFF, 8'hFE};
        for (int k = 0; k < 66; k++) q.push_back(8'h10 + 8'(k));
        i_osr_host_model.frame(q, 0, 0, rx);
        for (int k = 2; k < 66; k++) img[(62 + k) % 64] = 8'h10 + 8'(k);
        check({5'h00, userLocked, writeEnableLatch, readyBusyFlag}, 8'h05);
        status(s);
        check(s, 8'h01);
        i_osr_host_model.halfNs = 40;
        polls = 0;
        do begin
            status(s);
            polls++;
        end while (s[0] !== 1'b0 && polls < 20);
        i_osr_host_model.halfNs = 24;
        check(s, 8'h00);
        check({7'h00, busyCnt >= PROG - 2 && busyCnt <= PROG + 2}, 8'h01);
        read_check(8'h00, 128, 0);
    endtask

    task automatic t_reprogram();
        logic [7:0] q[$];
        wren(0);
        flags(8'h06);
        q = {osr_pkg::OP_PROG, 8'h00, 8'h00, 8'h00, 8'h55};
        i_osr_host_model.frame(q, 0, 0, rx);
        flags(8'h04);
        read_check(8'h3E, 4, 0);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        for (int n = 0; n < 128; n++) img[n] = (n < 64) ? 8'hFF : 8'hC0 ^ 8'(n - 64);
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_erased();
        t_wren();
        t_aborts();
        t_program();
        t_reprogram();
        stop_test();
    end

    // Whole run needs roughly 165 us of link traffic
    initial begin
        #400000;
        n_errors++;
        stop_test();
    end
endmodule
